// file: sdf_chan.sv
// Purpose: One channel: data filter and comparator filter on a modulator stream.
// Assumes: Clock and data inputs are already synchronised to sys_clk.
// Notes: Windows count ones over the ratio; a running change is not masked.
`timescale 1ns/1ps
`include "sdf_map.svh"
module sdf_chan
    import sdf_pkg::*;
(
    // Clock and reset.
    input  wire logic     sys_clk,
    input  wire logic     rst,
    // Modulator stream.
    input  wire logic     mclk_s,
    input  wire logic     mdat_s,
    input  wire logic     filt_rst,
    // Settings.
    input  wire logic     data_en,
    input  wire logic     comp_en,
    input  wire sdf_osr_t data_oversampling_ratio,
    input  wire sdf_osr_t comparator_oversampling_ratio,
    input  wire sdf_osr_t lower,
    input  wire sdf_osr_t upper,
    // Results.
    output sdf_osr_t      data_q,
    output logic          drdy,
    output logic          over,
    output logic          under
);
    logic     mclk_p;
    logic     rise;
    sdf_osr_t dcnt;
    sdf_osr_t dacc;
    sdf_osr_t ccnt;
    sdf_osr_t cacc;
    sdf_osr_t cval;

    // A count already past a newly lowered ratio ends the window at once.
    function automatic logic win_end(input sdf_osr_t cnt, input sdf_osr_t osr);
        return (9'(cnt) + 9'h001) >= {1'b0, osr};
    endfunction

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mclk_p <= 1'b0;
        end else begin
            mclk_p <= mclk_s;
        end
    end

    assign rise = mclk_s & ~mclk_p;
    assign cval = cacc + 8'(mdat_s);

    // Partial sums survive a disable, so the first window after enabling may be short.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dcnt   <= 8'h00;
            dacc   <= 8'h00;
            data_q <= 8'h00;
            drdy   <= 1'b0;
        end else begin
            drdy <= 1'b0;
            if (filt_rst) begin // [RL10]
                dcnt <= 8'h00;
                dacc <= 8'h00;
            end else if (rise && data_en) begin
                if (win_end(dcnt, data_oversampling_ratio)) begin // [RL8] [RL13]
                    data_q <= dacc + 8'(mdat_s);
                    dacc   <= 8'h00;
                    dcnt   <= 8'h00;
                    drdy   <= 1'b1;
                end else begin
                    dacc <= dacc + 8'(mdat_s);
                    dcnt <= dcnt + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ccnt  <= 8'h00;
            cacc  <= 8'h00;
            over  <= 1'b0;
            under <= 1'b0;
        end else begin
            over  <= 1'b0;
            under <= 1'b0;
            if (filt_rst) begin
                ccnt <= 8'h00;
                cacc <= 8'h00;
            end else if (rise && comp_en) begin
                if (win_end(ccnt, comparator_oversampling_ratio)) begin // [RL4]
                    over  <= cval > upper; // [RL1]
                    under <= cval < lower; // [RL1]
                    cacc  <= 8'h00;
                    ccnt  <= 8'h00;
                end else begin
                    cacc <= cval;
                    ccnt <= ccnt + 8'h01;
                end
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_drdy_enabled: assert property (drdy |-> $past(data_en) && $past(rise)) // [RL13]
        else $error("data ready without an enabled filter edge");
    a_cmp_cause: assert property ((over || under) |-> $past(comp_en) && $past(rise)) // [RL1]
        else $error("comparator event without an enabled filter edge");
endmodule

// file: sdf_map.svh
// Purpose: Register map, field positions and reset values of the sigma-delta filter events.
// Assumes: APB with 32-bit data; each register takes one aligned word.
// Notes: Channel registers sit at 0x40 + 0x10 * channel.
//
// Overview of operation
// RL1 - With comparator interrupts on, any of four channels may flag over or under spuriously.
// RL2 - Software programs the comparator oversampling ratio to five or more.
// RL3 - After a comparator ratio change, wait latency plus five clocks before the enables.
// RL4 - Running changes of thresholds, filter type or comparator ratio give spurious events.
// RL5 - Every comparator event reaches interrupt, accelerator trigger and crossbar trips; the code gates the first two by the compare interrupt enable and mask.
// RL6 - For a comparator change, software disables the interrupt, changes, waits, re-enables.
// RL7 - For a comparator change, software disables crossbar trips, changes, waits, re-enables.
// RL8 - A running data type or ratio change emits spurious data-ready, interrupt and DMA.
// RL9 - For a data filter change, software disables the filter, changes, waits, then enables.
// RL10 - With pulse sync, a PWM on that time base interrupts at least 1.2 us after the pulse.
// RL11 - The handler counts samples after each pulse, clears flags up to N and then leaves them.
// RL12 - On the two earliest revisions software keeps all comparator interrupt sources disabled.
// RL13 - One spurious data-ready may follow first enable; later ones follow the setting.
// RL14 - Interrupt flags stay set once raised until software clears them.
`ifndef SDF_MAP_SVH
`define SDF_MAP_SVH

`define SDF_FLAGS_OFS   8'h00
`define SDF_MASK_OFS    8'h04
`define SDF_CH_CTRL     2'h0
`define SDF_CH_THR      2'h1
`define SDF_CH_DATA     2'h2

`define SDF_CTRL_DEN    0
`define SDF_CTRL_CEN    1
`define SDF_CTRL_IEH    2
`define SDF_CTRL_IEL    3
`define SDF_CTRL_DATA_OVERSAMPLING_RATIO   15:8
`define SDF_CTRL_COMPARATOR_OVERSAMPLING_RATIO   23:16
`define SDF_THR_LOWER   7:0
`define SDF_THR_UPPER   15:8
`define SDF_FLG_DRDY    3:0
`define SDF_FLG_OVER    7:4
`define SDF_FLG_UNDER   11:8

`define SDF_CTRL_WMASK  32'h00FF_FF0F
`define SDF_THR_WMASK   32'h0000_FFFF
`define SDF_CTRL_RST    32'h0005_2000
`define SDF_THR_RST     32'h0000_FF00
`define SDF_FLG_RST     12'h000

`endif

// file: sdf_mod_model.sv
// Purpose: Behavioural modulator that feeds bit streams and clocks to the filter block.
// Assumes: One shared modulator clock of 2*HALF sys_clk cycles for all channels.
// Notes: Outside frames the clock stands low and the data lines toggle every cycle.
`timescale 1ns/1ps
module sdf_mod_model #(
    parameter int NCH  = 4,
    parameter int HALF = 4
)
(
    // Clock and reset.
    input  wire logic           sys_clk,
    input  wire logic           rst,
    // Stream control.
    input  wire logic           run,
    input  wire logic [NCH-1:0] level,
    // Modulator pins.
    output logic [NCH-1:0]      mod_clk,
    output logic [NCH-1:0]      mod_data
);
    int ph;

    // Data changes on the falling clock edge so it is steady at every rise.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ph       <= 0;
            mod_clk  <= '0;
            mod_data <= '0;
        end else if (run) begin
            ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
            if (ph == HALF - 1) begin
                mod_clk <= '1;
            end
            if (ph == 2 * HALF - 1) begin
                mod_clk  <= '0;
                mod_data <= level;
            end
        end else begin
            ph       <= 0;
            mod_clk  <= '0;
            mod_data <= ~mod_data;
        end
    end
endmodule

// file: sdf_pkg.sv
// Purpose: Shared types of the sigma-delta filter event block.
// Assumes: Eight-bit ratios and counts.
// Notes: None.
package sdf_pkg;
    typedef logic [7:0]  sdf_osr_t;
    typedef logic [11:0] sdf_flags_t;
endpackage

// file: sdf_top.sv
// Purpose: Four-channel sigma-delta filter event logic with an APB register file.
// Assumes: Modulator pins are asynchronous; filter_reset_pulse comes from sys_clk logic.
// Notes: pready is always high, so every access ends in its first access cycle.
`timescale 1ns/1ps
`include "sdf_map.svh"
module sdf_top
    import sdf_pkg::*;
#(
    parameter int NCH = 4
)
(
    // Clock and reset.
    input  wire logic            sys_clk,
    input  wire logic            rst,
    // APB slave.
    input  wire logic [7:0]      paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Modulator pins.
    input  wire logic [NCH-1:0]  mod_clk,
    input  wire logic [NCH-1:0]  mod_data,
    input  wire logic            filter_reset_pulse,
    // Event outputs.
    output logic                 irq,
    output logic                 accel_trig,
    output logic [NCH-1:0]       dma_req,
    output logic [NCH-1:0]       trip_hi,
    output logic [NCH-1:0]       trip_lo
);
    logic [NCH-1:0] mclk_m;
    logic [NCH-1:0] mclk_s;
    logic [NCH-1:0] mdat_m;
    logic [NCH-1:0] mdat_s;
    logic [31:0]    ctrl_q [NCH];
    logic [31:0]    thr_q  [NCH];
    sdf_osr_t       data_q [NCH];
    logic [NCH-1:0] drdy;
    logic [NCH-1:0] over;
    logic [NCH-1:0] under;
    logic [NCH-1:0] high_compare_irq_enable;
    logic [NCH-1:0] low_compare_irq_enable;
    sdf_flags_t     flags_q;
    sdf_flags_t     flags_d;
    sdf_flags_t     mask_q;
    sdf_flags_t     set_vec;
    sdf_flags_t     clr_vec;
    logic [31:0]    rd_d;
    logic           wr;
    logic [1:0]     ch;

    // True for a mapped word inside the channel window.
    function automatic logic ch_sel(input logic [7:0] a);
        return a[7:6] == 2'b01 && a[1:0] == 2'b00 && a[3:2] != 2'b11;
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        return a == `SDF_FLAGS_OFS || a == `SDF_MASK_OFS || ch_sel(a);
    endfunction

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~reg_hit(paddr);
    assign wr      = psel & penable & pwrite & reg_hit(paddr);
    assign ch      = paddr[5:4];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mclk_m <= '0;
            mclk_s <= '0;
            mdat_m <= '0;
            mdat_s <= '0;
        end else begin
            mclk_m <= mod_clk;
            mclk_s <= mclk_m;
            mdat_m <= mod_data;
            mdat_s <= mdat_m;
        end
    end

    // Settings take effect at once, even with the filter running.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                ctrl_q[c] <= `SDF_CTRL_RST;
                thr_q[c]  <= `SDF_THR_RST;
            end
        end else if (wr && ch_sel(paddr)) begin
            for (int c = 0; c < NCH; c++) begin
                if (ch == 2'(c) && paddr[3:2] == `SDF_CH_CTRL) begin
                    ctrl_q[c] <= pwdata & `SDF_CTRL_WMASK; // [RL4] [RL8]
                end
                if (ch == 2'(c) && paddr[3:2] == `SDF_CH_THR) begin
                    thr_q[c] <= pwdata & `SDF_THR_WMASK; // [RL4]
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            assign high_compare_irq_enable[g] = ctrl_q[g][`SDF_CTRL_IEH];
            assign low_compare_irq_enable[g] = ctrl_q[g][`SDF_CTRL_IEL];
            sdf_chan u_chan (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .mclk_s   (mclk_s[g]),
                .mdat_s   (mdat_s[g]),
                .filt_rst (filter_reset_pulse),
                .data_en  (ctrl_q[g][`SDF_CTRL_DEN]),
                .comp_en  (ctrl_q[g][`SDF_CTRL_CEN]),
                .data_oversampling_ratio     (ctrl_q[g][`SDF_CTRL_DATA_OVERSAMPLING_RATIO]),
                .comparator_oversampling_ratio     (ctrl_q[g][`SDF_CTRL_COMPARATOR_OVERSAMPLING_RATIO]),
                .lower    (thr_q[g][`SDF_THR_LOWER]),
                .upper    (thr_q[g][`SDF_THR_UPPER]),
                .data_q   (data_q[g]),
                .drdy     (drdy[g]),
                .over     (over[g]),
                .under    (under[g])
            );
        end
    endgenerate

    // A new event in the same cycle as its write-one clear keeps the flag set.
    always_comb begin
        set_vec = {under & low_compare_irq_enable, over & high_compare_irq_enable, drdy}; // [RL1] [RL8]
        clr_vec = '0;
        if (wr && paddr == `SDF_FLAGS_OFS) begin
            clr_vec = pwdata[11:0];
        end
        flags_d = (flags_q & ~clr_vec) | set_vec; // [RL14]
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags_q <= `SDF_FLG_RST;
        end else begin
            flags_q <= flags_d; // [RL14]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_q <= `SDF_FLG_RST;
        end else if (wr && paddr == `SDF_MASK_OFS) begin
            mask_q <= pwdata[11:0];
        end
    end

    assign irq = |(flags_q & mask_q); // [RL5]

    // Comparator events reach the crossbar whatever the interrupt enables say.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            accel_trig <= 1'b0;
            dma_req    <= '0;
            trip_hi    <= '0;
            trip_lo    <= '0;
        end else begin
            accel_trig <= |(set_vec & mask_q); // [RL5] [RL8]
            dma_req    <= drdy; // [RL8]
            trip_hi    <= over; // [RL5]
            trip_lo    <= under; // [RL5]
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (paddr == `SDF_FLAGS_OFS) begin
            rd_d = {20'h00000, flags_q};
        end else if (paddr == `SDF_MASK_OFS) begin
            rd_d = {20'h00000, mask_q};
        end else if (ch_sel(paddr)) begin
            case (paddr[3:2])
                `SDF_CH_CTRL: rd_d = ctrl_q[ch];
                `SDF_CH_THR:  rd_d = thr_q[ch];
                `SDF_CH_DATA: rd_d = {24'h000000, data_q[ch]};
                default:      rd_d = 32'h0000_0000;
            endcase
        end
    end

    // Read data is captured in the setup cycle and stands through the access cycle.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rd_d;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_flag_sticky: assert property (1'b1 |=> // [RL14]
        ((flags_q & $past(flags_q & ~clr_vec)) == $past(flags_q & ~clr_vec)))
        else $error("flag dropped without a clear");
    a_cmp_flag_set: assert property ((over & high_compare_irq_enable) != '0 |=> // [RL4]
        (flags_q[7:4] & $past(over & high_compare_irq_enable)) == $past(over & high_compare_irq_enable))
        else $error("enabled comparator event did not set its flag");
    a_drdy_dma: assert property (drdy != '0 |=> dma_req == $past(drdy)) // [RL8]
        else $error("data ready did not reach the DMA request");
    a_trip_route: assert property ((over | under) != '0 |=> // [RL5]
        trip_hi == $past(over) && trip_lo == $past(under))
        else $error("comparator event did not reach the trip outputs");
    // The mask may be rewritten at the event's edge, so the flag is judged against the old mask.
    a_accel_irq: assert property (accel_trig |-> // [RL5]
        (flags_q & $past(mask_q)) != '0 && $past((set_vec & mask_q) != '0))
        else $error("accelerator trigger without an unmasked event");
endmodule

// file: sdf_top_tb_top.sv
// Purpose: Self-checking bench of the four-channel filter event block.
// Assumes: APB slave answers when pready is high; modulator runs at 800 ns.
// Notes: First window after any enable may be short, so results use a later window.
`timescale 1ns/1ps
`include "sdf_map.svh"
module sdf_top_tb_top;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, frp, run, irq, accel_trig;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  mod_clk, mod_data, level, dma_req, trip_hi, trip_lo;
    int          n_mismatch, check_count;

    sdf_top sdf_top_i (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mod_clk(mod_clk), .mod_data(mod_data),
        .filter_reset_pulse(frp), .irq(irq), .accel_trig(accel_trig),
        .dma_req(dma_req), .trip_hi(trip_hi), .trip_lo(trip_lo));
    sdf_mod_model sdf_mod_model_i (.sys_clk(sys_clk), .rst(rst), .run(run),
        .level(level), .mod_clk(mod_clk), .mod_data(mod_data));

    initial begin
        sys_clk = 0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask

    function automatic logic evbit(input int k, input int c);
        case (k)
            0: return dma_req[c];
            1: return trip_hi[c];
            2: return trip_lo[c];
            default: return accel_trig;
        endcase
    endfunction

    task automatic wait_ev(input int k, input int c);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 1500 && hit !== 1'b1; n++) begin
            settle();
            hit = evbit(k, c);
        end
        chk({31'h0, hit}, 32'h1);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd(8'h40, `SDF_CTRL_RST);
        rd(8'h44, `SDF_THR_RST);
        rd(`SDF_FLAGS_OFS, 32'h0);
        rd(`SDF_MASK_OFS, 32'h0);
        wr(8'h70, 32'hFFFF_FFFF);
        rd(8'h70, `SDF_CTRL_WMASK);
        wr(8'h70, `SDF_CTRL_RST);
        apb(1'b1, 8'h30, 32'hFFFF_FFFF, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h30, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic t_data();
        wr(8'h50, 32'h0000_0201);
        wait_ev(0, 1);
        wait_ev(0, 1);
        rd(8'h58, 32'h0000_0002);
        rd(`SDF_FLAGS_OFS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0);
        wr(`SDF_MASK_OFS, 32'h0000_0002);
        settle();
        chk({31'h0, irq}, 32'h1);
        wr(8'h50, 32'h0000_0400);
        repeat (100) @(posedge sys_clk);
        wr(`SDF_FLAGS_OFS, 32'h0000_0002);
        settle();
        chk({31'h0, irq}, 32'h0);
        wr(8'h50, 32'h0000_0401);
        wait_ev(0, 1);
        wait_ev(0, 1);
        rd(8'h58, 32'h0000_0004);
        wr(8'h50, 32'h0000_0400);
        wr(`SDF_FLAGS_OFS, 32'h0000_0FFF);
        wr(`SDF_MASK_OFS, 32'h0);
    endtask

    task automatic t_comp();
        wr(8'h64, 32'h0000_0301);
        wr(8'h60, 32'h0005_0002);
        repeat (100) @(posedge sys_clk);
        wait_ev(1, 2);
        rd(`SDF_FLAGS_OFS, 32'h0);
        wr(`SDF_MASK_OFS, 32'h0000_0040);
        wr(8'h60, 32'h0005_0006);
        wait_ev(3, 0);
        rd(`SDF_FLAGS_OFS, 32'h0000_0040);
        chk({31'h0, irq}, 32'h1);
        level[2] <= 1'b0;
        wr(`SDF_MASK_OFS, 32'h0000_0400);
        wr(8'h60, 32'h0005_000A);
        wait_ev(2, 2);
        settle();
        rd(`SDF_FLAGS_OFS, 32'h0000_0440);
        wr(8'h60, 32'h0005_0000);
        wr(`SDF_FLAGS_OFS, 32'h0000_0FFF);
        wr(`SDF_MASK_OFS, 32'h0);
        level[2] <= 1'b1;
    endtask

    task automatic t_frp();
        localparam int N = 3;
        wr(8'h40, 32'h0000_0201);
        wr(`SDF_MASK_OFS, 32'h0000_0001);
        @(posedge sys_clk);
        frp <= 1'b1;
        @(posedge sys_clk);
        frp <= 1'b0;
        repeat (12) @(posedge sys_clk);
        wr(`SDF_FLAGS_OFS, 32'h0000_0001);
        for (int k = 0; k <= N; k++) begin
            wait_ev(0, 0);
            if (k < N) begin
                wr(`SDF_FLAGS_OFS, 32'h0000_0001);
            end
        end
        wait_ev(0, 0);
        rd(`SDF_FLAGS_OFS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h1);
        wr(8'h40, 32'h0000_0200);
    endtask

    initial begin
        #(30000 * 100);
        n_mismatch++;
        summarize();
    end

    initial begin
        rst         = 1'b1;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        frp         = 1'b0;
        run         = 1'b0;
        level       = 4'hF;
        n_mismatch  = 0;
        check_count = 0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        run <= 1'b1;
        t_data();
        t_comp();
        t_frp();
        summarize();
    end
endmodule
